// ===== logic/mprs_top.sv
// power button, reset and suspend signal sequencer with APB registers
`timescale 1ns/100ps
`include "mprs_cfg.svh"
module mprs_top #(
   parameter int WD_W = 16
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // APB slave
   input wire mprs_pkg::mprs_apb_req_s apb_req,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // carrier pins in
   input wire logic pwr_button_n,
   input wire logic reset_button_n,
   input wire logic supply_good,
   input wire logic main_supply_input_low,
   // carrier pins out
   output logic carrier_reset_n,
   output logic suspend_imminent_n,
   output logic suspend_to_ram_n,
   output logic suspend_to_disk_n,
   // interrupt
   output logic irq
);
   import mprs_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // input synchronisers and watchdog

   mprs_pins_s pins_raw; // raw pins, supply monitor turned to active-low fault
   mprs_pins_s lvl; // synchronised levels
   mprs_pins_s fall; // synchronised falling pulses
   logic wdog_to; // watchdog expiry pulse
   logic wd_en_reg, wd_en_next; // watchdog enable
   logic [WD_W-1:0] wd_load_reg, wd_load_next; // watchdog reload
   logic wd_kick; // kick strobe
   mprs_state_e state_reg, state_next; // sequencer state

   assign pins_raw = '{pwr_button_n, reset_button_n, supply_good, ~main_supply_input_low};

   mprs_sync #(.W(4), .RST_VAL(4'hD)) u_sync (
      .ref_clk(ref_clk),
      .srst(srst),
      .pin_in(pins_raw),
      .level(lvl),
      .fall(fall)
   );

   // watchdog only runs while the system is up
   // reload taken from the next value so an enabling write starts from its own count
   mprs_wdog #(.CW(WD_W)) u_wdog (
      .ref_clk(ref_clk),
      .srst(srst),
      .enable(wd_en_reg && state_reg == MPRS_RUN),
      .kick(wd_kick),
      .load(wd_load_next),
      .timeout(wdog_to)
   );

   ////////////////////////////////////////////////////////////////////////////
   // APB slave: one wait state, access completes with pready

   logic acc; // access phase seen with pready already up
   logic wr_acc, rd_acc; // completing write / read
   logic [2:0] sel; // word index
   logic mapped; // address hits a register
   logic pready_reg, pready_next;
   logic pslverr_reg, pslverr_next;
   logic [31:0] prdata_reg, prdata_next;
   logic [1:0] tgt_reg, tgt_next; // suspend target
   logic sw_rst; // software reset strobe
   logic sus_cmd; // suspend command strobe
   logic [`MPRS_EV_W-1:0] sts_reg, sts_next; // sticky events
   logic [`MPRS_EV_W-1:0] mask_reg, mask_next; // interrupt mask
   logic [`MPRS_EV_W-1:0] ev; // event pulses this cycle
   logic irq_reg, irq_next;

   assign acc = apb_req.psel && apb_req.penable && pready_reg;
   assign wr_acc = acc && apb_req.pwrite && mapped;
   assign rd_acc = acc && !apb_req.pwrite && mapped;
   assign sel = apb_req.paddr[4:2];
   assign mapped = (apb_req.paddr[1:0] == 2'h0) && (apb_req.paddr <= `MPRS_WDKICK_OFS);
   assign sw_rst = wr_acc && sel == 3'(`MPRS_CTRL_OFS >> 2) && apb_req.pwdata[`MPRS_CTRL_SWRST];
   assign sus_cmd = wr_acc && sel == 3'(`MPRS_CTRL_OFS >> 2);
   assign wd_kick = wr_acc && sel == 3'(`MPRS_WDKICK_OFS >> 2);

   // register writes, read mux, read-clear of status with set winning
   always_comb begin
      pready_next = apb_req.psel && apb_req.penable && !pready_reg;
      pslverr_next = pready_next && !mapped;
      prdata_next = 32'h0;
      tgt_next = tgt_reg;
      mask_next = mask_reg;
      wd_en_next = wd_en_reg;
      wd_load_next = wd_load_reg;
      sts_next = sts_reg;
      if (pready_next && mapped && !apb_req.pwrite) begin
         unique case (sel)
            3'(`MPRS_CTRL_OFS >> 2): prdata_next = 32'({tgt_reg, 1'b0});
            3'(`MPRS_STS_OFS >> 2): prdata_next = 32'(sts_reg);
            3'(`MPRS_MASK_OFS >> 2): prdata_next = 32'(mask_reg);
            3'(`MPRS_STATE_OFS >> 2): prdata_next = 32'({lvl, carrier_reset_n, 1'b0, state_reg});
            3'(`MPRS_WDCFG_OFS >> 2): prdata_next = 32'({wd_en_reg, wd_load_reg});
            default: prdata_next = 32'h0;
         endcase
      end
      if (wr_acc) begin
         unique case (sel)
            3'(`MPRS_CTRL_OFS >> 2): tgt_next = apb_req.pwdata[`MPRS_CTRL_TGT_LO +: 2];
            3'(`MPRS_MASK_OFS >> 2): mask_next = apb_req.pwdata[`MPRS_EV_W-1:0];
            3'(`MPRS_WDCFG_OFS >> 2): begin
               wd_en_next = apb_req.pwdata[`MPRS_WD_EN];
               wd_load_next = apb_req.pwdata[WD_W-1:0];
            end
            default: tgt_next = tgt_reg;
         endcase
      end
      // status clears on a completing read, then new events are set on top
      if (rd_acc && sel == 3'(`MPRS_STS_OFS >> 2)) begin
         sts_next = '0;
      end
      sts_next = sts_next | ev;
      irq_next = |(sts_next & mask_next);
   end

   // register bus state
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0;
         tgt_reg <= `MPRS_TGT_NONE;
         mask_reg <= '0;
         wd_en_reg <= 1'b0;
         wd_load_reg <= WD_W'(`MPRS_WD_LOAD_RST);
         sts_reg <= '0;
         irq_reg <= 1'b0;
      end else begin
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         prdata_reg <= prdata_next;
         tgt_reg <= tgt_next;
         mask_reg <= mask_next;
         wd_en_reg <= wd_en_next;
         wd_load_reg <= wd_load_next;
         sts_reg <= sts_next;
         irq_reg <= irq_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // power and suspend sequencer

   logic [11:0] cnt_reg, cnt_next; // hold / warning timer
   logic wake; // button wake from suspend
   logic reset_cause; // any reason to hold the carrier in reset
   logic crst_n_reg, imm_n_reg, ram_n_reg, disk_n_reg; // output flops

   assign wake = fall.pwr_button_n && (state_reg == MPRS_RAM || state_reg == MPRS_DISK);

   // event pulses for the status register
   always_comb begin
      ev = '0;
      ev[`MPRS_EV_PBTN] = fall.pwr_button_n;
      ev[`MPRS_EV_RBTN] = fall.reset_button_n;
      ev[`MPRS_EV_GOOD] = fall.supply_good;
      ev[`MPRS_EV_SUPPLY] = fall.supply_ok;
      ev[`MPRS_EV_WDOG] = wdog_to;
      ev[`MPRS_EV_WAKE] = wake;
   end

   // next state: reset requests first, then wake, then suspend flow
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      if (fall.reset_button_n || sw_rst ||
          wdog_to) begin
         state_next = MPRS_RESET;
         cnt_next = 12'(`MPRS_RST_HOLD_CYC);
      end else begin
         unique case (state_reg)
            MPRS_WAIT_GOOD: begin
               if (lvl.supply_good && lvl.supply_ok) begin
                  state_next = MPRS_RUN;
               end
            end
            MPRS_RESET: begin
               if (cnt_reg == 12'h000) begin
                  state_next = MPRS_WAIT_GOOD;
               end else begin
                  cnt_next = cnt_reg - 12'h001;
               end
            end
            MPRS_RUN: begin
               if (!lvl.supply_good || !lvl.supply_ok) begin
                  state_next = MPRS_WAIT_GOOD;
               end else if (sus_cmd && tgt_next != `MPRS_TGT_NONE) begin
                  state_next = MPRS_WARN;
                  cnt_next = 12'(`MPRS_WARN_CYC);
               end
            end
            MPRS_WARN: begin
               if (cnt_reg != 12'h000) begin
                  cnt_next = cnt_reg - 12'h001;
               end else if (tgt_reg == `MPRS_TGT_DISK) begin
                  state_next = MPRS_DISK;
               end else begin
                  state_next = MPRS_RAM;
               end
            end
            MPRS_RAM, MPRS_DISK: begin
               if (wake) begin
                  state_next = MPRS_WAIT_GOOD;
               end
            end
            default: state_next = MPRS_WAIT_GOOD;
         endcase
      end
      reset_cause = !lvl.reset_button_n || !lvl.supply_good || !lvl.supply_ok ||
                    state_next == MPRS_RESET || state_next == MPRS_WAIT_GOOD;
   end

   // sequencer and pin output flops
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state_reg <= MPRS_WAIT_GOOD;
         cnt_reg <= 12'h000;
         crst_n_reg <= 1'b0;
         imm_n_reg <= 1'b1;
         ram_n_reg <= 1'b1;
         disk_n_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         crst_n_reg <= !reset_cause;
         imm_n_reg <= !(state_next == MPRS_WARN || state_next == MPRS_RAM ||
                        state_next == MPRS_DISK);
         ram_n_reg <= state_next != MPRS_RAM;
         disk_n_reg <= state_next != MPRS_DISK;
      end
   end

   assign carrier_reset_n = crst_n_reg;
   assign suspend_imminent_n = imm_n_reg;
   assign suspend_to_ram_n = ram_n_reg;
   assign suspend_to_disk_n = disk_n_reg;
   assign irq = irq_reg;
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   btn_event_a: assert property (fall.pwr_button_n |=> sts_reg[`MPRS_EV_PBTN])
      else $error("power button edge not recorded");
   wake_up_a: assert property (wake && !fall.reset_button_n && !sw_rst |=> state_reg == MPRS_WAIT_GOOD)
      else $error("button did not wake from suspend");
   reboot_req_a: assert property (fall.reset_button_n |=> state_reg == MPRS_RESET ##1 !carrier_reset_n)
      else $error("reset button did not reboot");
   rst_button_a: assert property (!lvl.reset_button_n |=> !carrier_reset_n)
      else $error("reset out missing for reset button");
   rst_good_a: assert property (!lvl.supply_good |=> !carrier_reset_n)
      else $error("reset out missing for power-good low");
   rst_supply_a: assert property (!lvl.supply_ok |=> !carrier_reset_n)
      else $error("reset out missing for low main supply");
   rst_wdog_a: assert property (wdog_to |=> !carrier_reset_n [*8])
      else $error("watchdog reset too short");
   hold_start_a: assert property (state_reg == MPRS_WAIT_GOOD && !lvl.supply_good &&
      !fall.reset_button_n && !sw_rst |=> state_reg == MPRS_WAIT_GOOD)
      else $error("startup while power-good low");
   warn_first_a: assert property ($rose(state_reg == MPRS_RAM || state_reg == MPRS_DISK)
      |-> !$past(suspend_imminent_n) && $past(state_reg) == MPRS_WARN)
      else $error("suspend entered without warning");
   imm_out_a: assert property (suspend_imminent_n ==
      !(state_reg inside {MPRS_WARN, MPRS_RAM, MPRS_DISK}))
      else $error("suspend warning output wrong");
   hold_rst_a: assert property (state_reg == MPRS_RESET |-> !carrier_reset_n)
      else $error("carrier reset released during hold");
   ram_out_a: assert property (suspend_to_ram_n == (state_reg != MPRS_RAM))
      else $error("suspend-to-RAM output wrong");
   disk_out_a: assert property (suspend_to_disk_n == (state_reg != MPRS_DISK))
      else $error("suspend-to-disk output wrong");
endmodule

// ===== pkg/mprs_cfg.svh
// register map, field positions, reset values and timing counts of the power and reset block
`ifndef MPRS_CFG_SVH
`define MPRS_CFG_SVH

// register byte offsets
`define MPRS_CTRL_OFS 8'h00
`define MPRS_STS_OFS 8'h04
`define MPRS_MASK_OFS 8'h08
`define MPRS_STATE_OFS 8'h0C
`define MPRS_WDCFG_OFS 8'h10
`define MPRS_WDKICK_OFS 8'h14

// control fields
`define MPRS_CTRL_SWRST 0
`define MPRS_CTRL_TGT_LO 1

// status and mask bit positions
`define MPRS_EV_PBTN 0
`define MPRS_EV_RBTN 1
`define MPRS_EV_GOOD 2
`define MPRS_EV_SUPPLY 3
`define MPRS_EV_WDOG 4
`define MPRS_EV_WAKE 5
`define MPRS_EV_W 6

// watchdog config fields
`define MPRS_WD_EN 16
`define MPRS_WD_LOAD_RST 16'hFFFF

// suspend target codes
`define MPRS_TGT_NONE 2'h0
`define MPRS_TGT_RAM 2'h1
`define MPRS_TGT_DISK 2'h2

// timing: clock rate and least times, cycle counts round up
`define MPRS_CLK_MHZ 200
`define MPRS_RST_HOLD_NS 1000
`define MPRS_WARN_NS 2000
`define MPRS_RST_HOLD_CYC ((`MPRS_RST_HOLD_NS * `MPRS_CLK_MHZ + 999) / 1000)
`define MPRS_WARN_CYC ((`MPRS_WARN_NS * `MPRS_CLK_MHZ + 999) / 1000)

`endif

// ===== pkg/mprs_pkg.sv
// types shared by the power and reset block
package mprs_pkg;
   // sequencer states
   typedef enum logic [2:0] {
      MPRS_WAIT_GOOD,
      MPRS_RESET,
      MPRS_RUN,
      MPRS_WARN,
      MPRS_RAM,
      MPRS_DISK
   } mprs_state_e;

   // carrier-facing input levels after synchronising
   typedef struct packed {
      logic pwr_button_n;
      logic reset_button_n;
      logic supply_good;
      logic supply_ok;
   } mprs_pins_s;

   // APB request from the master
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } mprs_apb_req_s;
endpackage

// ===== logic/mprs_sync.sv
// three-stage pin synchroniser with agreement filter and falling-edge pulse
`timescale 1ns/100ps
module mprs_sync #(
   parameter int W = 4,
   parameter logic [W-1:0] RST_VAL = '1
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // raw pins
   input wire logic [W-1:0] pin_in,
   // filtered levels and one-cycle falling pulses
   output logic [W-1:0] level,
   output logic [W-1:0] fall
);
   logic [W-1:0] s1_reg, s2_reg, s3_reg; // sync stages
   logic [W-1:0] filt_reg, filt_next; // accepted level
   logic [W-1:0] fall_reg, fall_next; // falling pulse

   // a change counts once stages two and three agree
   always_comb begin
      filt_next = filt_reg;
      for (int i = 0; i < W; i++) begin
         if (s2_reg[i] == s3_reg[i]) begin
            filt_next[i] = s3_reg[i];
         end
      end
      fall_next = filt_reg & ~filt_next;
   end

   // register stages; first stage feeds only the second
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         s1_reg <= RST_VAL;
         s2_reg <= RST_VAL;
         s3_reg <= RST_VAL;
         filt_reg <= RST_VAL;
         fall_reg <= '0;
      end else begin
         s1_reg <= pin_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         filt_reg <= filt_next;
         fall_reg <= fall_next;
      end
   end

   assign level = filt_reg;
   assign fall = fall_reg;
endmodule

// ===== logic/mprs_wdog.sv
// reloadable watchdog counter with a one-cycle timeout pulse
`timescale 1ns/100ps
module mprs_wdog #(
   parameter int CW = 16
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // control
   input wire logic enable,
   input wire logic kick,
   input wire logic [CW-1:0] load,
   // timeout event
   output logic timeout
);
   logic [CW-1:0] cnt_reg, cnt_next; // remaining count
   logic to_reg, to_next; // timeout pulse

   // count down while enabled, reload on kick, disable or expiry
   always_comb begin
      cnt_next = cnt_reg;
      to_next = 1'b0;
      if (!enable || kick) begin
         cnt_next = load;
      end else if (cnt_reg == '0) begin
         to_next = 1'b1;
         cnt_next = load;
      end else begin
         cnt_next = cnt_reg - CW'(1);
      end
   end

   // register counter and pulse
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cnt_reg <= '1;
         to_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         to_reg <= to_next;
      end
   end

   assign timeout = to_reg;
endmodule

// ===== tb/mprs_carrier.sv
// behavioural model of the carrier board pins around the sequencer
`timescale 1ns/100ps
module mprs_carrier (
   // clock
   input wire logic ref_clk,
   // pins toward the module
   output logic pwr_button_n,
   output logic reset_button_n,
   output logic supply_good,
   output logic main_supply_input_low,
   // suspend indication from the module and the supply on request made from it
   input wire logic suspend_to_ram_n,
   output logic psu_on_n
);
   //////////////////////////////
   // buttons idle at their pull-up level, power-good starts low to hold off startup
   initial begin
      pwr_button_n = 1'b1;
      reset_button_n = 1'b1;
      supply_good = 1'b0;
      main_supply_input_low = 1'b0;
   end

   // inverted ram indication drives the supply's active-low on input
   assign psu_on_n = ~suspend_to_ram_n;

   //////////////////////////////
   // moves one pin just after a clock edge: 0 power, 1 reset, 2 good, 3 supply low
   // a button request is always a fresh fall from the released level
   task automatic pin(input int which, input logic v);
      @(posedge ref_clk);
      case (which)
         0: pwr_button_n <= v;
         1: reset_button_n <= v;
         2: supply_good <= v;
         default: main_supply_input_low <= v;
      endcase
   endtask
endmodule

// ===== tb/tb.sv
// self-checking bench for the power and reset sequencer
`timescale 1ns/100ps
`include "mprs_cfg.svh"
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin n_fail++; \
   $display("[FAIL] %s expected %h got %h", nm, exp, got); end end
module tb;
   import mprs_pkg::*;
   // clock, reset and bus
   logic ref_clk;
   logic srst;
   mprs_apb_req_s req;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   // carrier pins
   logic pwr_button_n;
   logic reset_button_n;
   logic supply_good;
   logic main_supply_input_low;
   logic carrier_reset_n;
   logic suspend_imminent_n;
   logic suspend_to_ram_n;
   logic suspend_to_disk_n;
   logic irq;
   logic psu_on_n;
   // outputs packed as reset, imminent, ram, disk
   logic [3:0] outs;
   int n_fail;
   int n_tests;
   logic [31:0] q;
   logic e;

   assign outs = {carrier_reset_n, suspend_imminent_n, suspend_to_ram_n, suspend_to_disk_n};

   // 200 MHz clock
   initial ref_clk = 1'b0;
   always #2.5 ref_clk = ~ref_clk;

   //////////////////////////////
   mprs_top #(.WD_W(16)) mprs_top_i (.ref_clk(ref_clk), .srst(srst), .apb_req(req), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pwr_button_n(pwr_button_n), .reset_button_n(reset_button_n),
      .supply_good(supply_good), .main_supply_input_low(main_supply_input_low),
      .carrier_reset_n(carrier_reset_n), .suspend_imminent_n(suspend_imminent_n),
      .suspend_to_ram_n(suspend_to_ram_n), .suspend_to_disk_n(suspend_to_disk_n), .irq(irq));
   mprs_carrier mprs_carrier_i (.ref_clk(ref_clk), .pwr_button_n(pwr_button_n),
      .reset_button_n(reset_button_n), .supply_good(supply_good),
      .main_supply_input_low(main_supply_input_low), .suspend_to_ram_n(suspend_to_ram_n), .psu_on_n(psu_on_n));

   //////////////////////////////
   // one apb transfer: setup, access held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge ref_clk);
      req.penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      `CHK("apb answer", 1'b1, pready)
      `CHK("apb wait states", 2, n)
      req <= '0;
   endtask

   // read and compare the masked bits
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x, input string nm);
      apb(1'b0, a, 32'h0);
      `CHK(nm, x, q & m)
   endtask

   // wait a bounded time for one output to reach a level
   task automatic wait_out(input int i, input logic v, input int lim, input string nm);
      int n;
      n = 0;
      while (outs[i] !== v && n < lim) begin
         @(posedge ref_clk);
         n++;
      end
      `CHK(nm, v, outs[i])
   endtask

   task automatic test_end(input string nm);
      $display("test %s done, fails so far %0d", nm, n_fail);
   endtask

   // prints the counts and the verdict, then stops
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   //////////////////////////////
   // hang guard, far beyond the roughly 1800 cycles the tests need
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_fail++;
      final_report();
   end

   //////////////////////////////
   initial begin
      n_fail = 0;
      n_tests = 0;
      srst = 1'b1;
      req = '0;
      repeat (8) @(posedge ref_clk);
      srst <= 1'b0;
      // startup waits for power-good
      repeat (30) @(posedge ref_clk);
      `CHK("held off", 1'b0, carrier_reset_n)
      mprs_carrier_i.pin(2, 1'b1);
      wait_out(3, 1'b1, 20, "startup");
      rd_chk(`MPRS_MASK_OFS, 32'hFFFFFFFF, 32'h0, "mask reset");
      rd_chk(`MPRS_WDCFG_OFS, 32'hFFFFFFFF, 32'h0000FFFF, "wdcfg reset");
      rd_chk(`MPRS_STATE_OFS, 32'h1F7, 32'h1F2, "state levels");
      apb(1'b0, 8'h18, 32'h0);
      `CHK("unmapped err", 1'b1, e)
      `CHK("unmapped data", 32'h0, q)
      test_end("startup");
      // power button event in run, unmasked then masked
      apb(1'b1, `MPRS_MASK_OFS, 32'h1);
      apb(1'b0, `MPRS_STS_OFS, 32'h0);
      for (int m = 1; m >= 0; m--) begin
         apb(1'b1, `MPRS_MASK_OFS, 32'(m));
         mprs_carrier_i.pin(0, 1'b0);
         repeat (8) @(posedge ref_clk);
         `CHK("irq", 1'(m), irq)
         `CHK("run kept", 4'hF, outs)
         mprs_carrier_i.pin(0, 1'b1);
         rd_chk(`MPRS_STS_OFS, 32'h1, 32'h1, "button event");
         repeat (2) @(posedge ref_clk);
         `CHK("irq cleared", 1'b0, irq)
      end
      rd_chk(`MPRS_STS_OFS, 32'h1, 32'h0, "read clears");
      test_end("button");
      // suspend to ram then to disk, each woken by the power button
      for (int t = 1; t <= 2; t++) begin
         apb(1'b1, `MPRS_CTRL_OFS, 32'(t) << 1);
         repeat (2) @(posedge ref_clk);
         `CHK("warning", 4'hB, outs)
         repeat (380) @(posedge ref_clk);
         `CHK("warning held", 4'hB, outs)
         wait_out(t == 1 ? 1 : 0, 1'b0, 40, "suspended");
         `CHK("suspend outs", t == 1 ? 4'h9 : 4'hA, outs)
         `CHK("supply off request", 1'(t == 1), psu_on_n)
         mprs_carrier_i.pin(0, 1'b0);
         wait_out(2, 1'b1, 12, "wake");
         wait_out(3, 1'b1, 20, "rerun");
         mprs_carrier_i.pin(0, 1'b1);
         `CHK("awake outs", 4'hF, outs)
         `CHK("supply on request", 1'b0, psu_on_n)
         rd_chk(`MPRS_STS_OFS, 32'h20, 32'h20, "wake event");
      end
      test_end("suspend");
      // reset button, with synchroniser delay and hold while low
      mprs_carrier_i.pin(1, 1'b0);
      @(posedge ref_clk);
      `CHK("sync delay", 1'b1, carrier_reset_n)
      wait_out(3, 1'b0, 8, "button reset");
      repeat (300) @(posedge ref_clk);
      `CHK("held by button", 1'b0, carrier_reset_n)
      mprs_carrier_i.pin(1, 1'b1);
      wait_out(3, 1'b1, 300, "reboot");
      rd_chk(`MPRS_STS_OFS, 32'h2, 32'h2, "reset event");
      test_end("reset button");
      // power-good low, then main supply low
      for (int i = 2; i <= 3; i++) begin
         mprs_carrier_i.pin(i, 1'(i == 3));
         wait_out(3, 1'b0, 8, "supply reset");
         mprs_carrier_i.pin(i, 1'(i != 3));
         wait_out(3, 1'b1, 300, "supply back");
      end
      test_end("supply");
      // software reset strobe, hold time respected
      apb(1'b1, `MPRS_CTRL_OFS, 32'h1);
      wait_out(3, 1'b0, 4, "soft reset");
      repeat (150) @(posedge ref_clk);
      `CHK("hold", 1'b0, carrier_reset_n)
      wait_out(3, 1'b1, 300, "soft back");
      // watchdog kept alive by kicks, then left to expire
      apb(1'b1, `MPRS_WDCFG_OFS, 32'h00010014);
      repeat (3) begin
         repeat (10) @(posedge ref_clk);
         apb(1'b1, `MPRS_WDKICK_OFS, 32'h0);
      end
      `CHK("kicked", 1'b1, carrier_reset_n)
      wait_out(3, 1'b0, 40, "wdog reset");
      apb(1'b1, `MPRS_WDCFG_OFS, 32'h0);
      wait_out(3, 1'b1, 300, "wdog back");
      rd_chk(`MPRS_STS_OFS, 32'h10, 32'h10, "wdog event");
      test_end("software and watchdog");
      // mid-run reset returns outputs and mask to their reset levels
      apb(1'b1, `MPRS_MASK_OFS, 32'h3F);
      srst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      `CHK("reset outs", 4'h7, outs)
      `CHK("reset irq", 1'b0, irq)
      srst <= 1'b0;
      rd_chk(`MPRS_MASK_OFS, 32'hFFFFFFFF, 32'h0, "mask cleared");
      wait_out(3, 1'b1, 20, "restart");
      rd_chk(`MPRS_STS_OFS, 32'h3F, 32'h0, "no false events");
      test_end("mid-run reset");
      final_report();
   end
endmodule
